//--- core/flash_guard_pkg.sv
// shared constants and types for the flash abort guard ends
package flash_guard_pkg;
	localparam int ADDR_W  = 4;
	localparam int DATA_W  = 16;
	localparam int LEVEL_W = 2;
	localparam int CNT_W   = 16;

	// clock rate and abort blackout times
	localparam int CLK_MHZ        = 40;
	localparam int ABORT_BANK_US  = 100;
	localparam int ABORT_SEG_US   = 6;
	localparam int ABORT_BANK_CYC = ABORT_BANK_US * CLK_MHZ;
	localparam int ABORT_SEG_CYC  = ABORT_SEG_US * CLK_MHZ;

	// default operation and settling lengths in cycles
	localparam int WRITE_CYC_DEF      = 64;
	localparam int SEG_ERASE_CYC_DEF  = 1000;
	localparam int BANK_ERASE_CYC_DEF = 4000;
	localparam int MASS_ERASE_CYC_DEF = 4000;
	localparam int SETTLE_CYC_DEF     = 32;

	localparam logic [DATA_W-1:0] ERASED_WORD = 16'hFFFF;
	localparam logic              MON_LOW     = 1'h0;
	localparam logic              MON_HIGH    = 1'h1;

	typedef enum logic [1:0] {
		OP_WRITE      = 2'h0,
		OP_SEG_ERASE  = 2'h1,
		OP_BANK_ERASE = 2'h2,
		OP_MASS_ERASE = 2'h3
	} op_kind_type;

	typedef enum logic [0:0] {
		DEV_IDLE = 1'h0,
		DEV_BUSY = 1'h1
	} dev_state_type;

	typedef enum logic [2:0] {
		HOST_IDLE     = 3'h0,
		HOST_OP       = 3'h1,
		HOST_BLACKOUT = 3'h2,
		HOST_HI_WAIT  = 3'h3,
		HOST_CORE     = 3'h4,
		HOST_LO_WAIT  = 3'h5
	} host_state_type;
endpackage

//--- core/flash_guard_if.sv
// link between the processor core end and the flash end
`timescale 1ns/1ps
interface flash_guard_if;
	// flash operations
	logic                                op_start;
	flash_guard_pkg::op_kind_type        op_kind;
	logic [flash_guard_pkg::ADDR_W-1:0]  op_addr;
	logic [flash_guard_pkg::DATA_W-1:0]  op_data;
	logic                                emergency_abort_bit;
	logic                                busy;
	// flash reads
	logic                                rd;
	logic                                rd_valid;
	logic                                rd_good;
	logic [flash_guard_pkg::DATA_W-1:0]  rd_data;
	// supply monitors
	logic                                mon_prog;
	logic                                mon_sel;
	logic [flash_guard_pkg::LEVEL_W-1:0] high_release_level_unit;
	logic                                high_monitor_enable;
	logic                                high_supervisor_enable;
	logic                                low_monitor_enable;
	logic                                low_monitor_full_perf;
	logic                                core_set;
	logic [flash_guard_pkg::LEVEL_W-1:0] core_level;
	logic                                flag_clr;
	logic                                high_settle_flag;
	logic                                monitor_settle_delay_flag;
	// interrupt request toward the core
	logic                                irq_req;

	modport device_end (
		input  op_start, op_kind, op_addr, op_data, emergency_abort_bit,
		input  rd, mon_prog, mon_sel, high_release_level_unit,
		input  high_monitor_enable, high_supervisor_enable,
		input  low_monitor_enable, low_monitor_full_perf,
		input  core_set, core_level, flag_clr,
		output busy, rd_valid, rd_good, rd_data,
		output high_settle_flag, monitor_settle_delay_flag, irq_req
	);
	modport host_end (
		output op_start, op_kind, op_addr, op_data, emergency_abort_bit,
		output rd, mon_prog, mon_sel, high_release_level_unit,
		output high_monitor_enable, high_supervisor_enable,
		output low_monitor_enable, low_monitor_full_perf,
		output core_set, core_level, flag_clr,
		input  busy, rd_valid, rd_good, rd_data,
		input  high_settle_flag, monitor_settle_delay_flag, irq_req
	);
endinterface // flash_guard_if

//--- core/flash_abort_device.sv
// flash end: write/erase sequencer, abort recovery, monitor settling
`timescale 1ns/1ps
module flash_abort_device #(
	parameter int WRITE_CYC      = flash_guard_pkg::WRITE_CYC_DEF,
	parameter int SEG_ERASE_CYC  = flash_guard_pkg::SEG_ERASE_CYC_DEF,
	parameter int BANK_ERASE_CYC = flash_guard_pkg::BANK_ERASE_CYC_DEF,
	parameter int MASS_ERASE_CYC = flash_guard_pkg::MASS_ERASE_CYC_DEF,
	parameter int SETTLE_CYC     = flash_guard_pkg::SETTLE_CYC_DEF
) (
	// clock and reset
	input  wire logic                  core_clk_in,
	input  wire logic                  reset_in,
	// link to the core
	flash_guard_if.device_end          fl,
	// user side
	input  wire logic                  irq_src_in,
	output logic                       op_done_out,
	output logic                       op_aborted_out,
	output logic                       recovering_out,
	output logic                       read_corrupt_out
);
	localparam int DW = flash_guard_pkg::DATA_W;
	localparam int CW = flash_guard_pkg::CNT_W;
	localparam int DEPTH = 1 << flash_guard_pkg::ADDR_W;

	flash_guard_pkg::dev_state_type      state_q, state_d;
	flash_guard_pkg::op_kind_type        kind_q, kind_d;
	logic [flash_guard_pkg::ADDR_W-1:0]  addr_q, addr_d;
	logic [DW-1:0]                       wdata_q, wdata_d;
	logic [CW-1:0]                       cnt_q, cnt_d, rec_q, rec_d;
	logic [CW-1:0]                       lo_cnt_q, lo_cnt_d, hi_cnt_q, hi_cnt_d;
	logic                                lo_flag_q, lo_flag_d;
	logic                                hi_flag_q, hi_flag_d;
	logic                                lo_en_q, lo_en_d;
	logic                                done_q, done_d, abt_q, abt_d;
	logic                                rv_q, rv_d, rg_q, rg_d, bad_q, bad_d;
	logic [DW-1:0]                       rdat_q, rdat_d;
	logic                                irq_q;
	logic                                lo_expire, hi_expire;
	logic                                mem_wr, mem_erase_all;
	logic [DW-1:0]                       mem [DEPTH];

	always_comb begin
		state_d = state_q;
		kind_d = kind_q;
		addr_d = addr_q;
		wdata_d = wdata_q;
		cnt_d = cnt_q;
		rec_d = (rec_q != '0) ? rec_q - CW'(1) : rec_q;
		done_d = 1'b0;
		abt_d = 1'b0;
		mem_wr = 1'b0;
		mem_erase_all = 1'b0;
		case (state_q)
			flash_guard_pkg::DEV_IDLE: begin
				if (fl.op_start) begin
					state_d = flash_guard_pkg::DEV_BUSY;
					kind_d = fl.op_kind;
					addr_d = fl.op_addr;
					wdata_d = fl.op_data;
					case (fl.op_kind)
						flash_guard_pkg::OP_WRITE:      cnt_d = CW'(WRITE_CYC);
						flash_guard_pkg::OP_SEG_ERASE:  cnt_d = CW'(SEG_ERASE_CYC);
						flash_guard_pkg::OP_BANK_ERASE: cnt_d = CW'(BANK_ERASE_CYC);
						default:                        cnt_d = CW'(MASS_ERASE_CYC);
					endcase
				end
			end
			flash_guard_pkg::DEV_BUSY: begin
				cnt_d = cnt_q - CW'(1);
				// abort beats a completion landing in the same cycle
				if (fl.emergency_abort_bit) begin
					state_d = flash_guard_pkg::DEV_IDLE;
					abt_d = 1'b1;
					// the aborted cell contents are left as they were
					if (kind_q == flash_guard_pkg::OP_BANK_ERASE ||
					    kind_q == flash_guard_pkg::OP_MASS_ERASE)
						rec_d = CW'(flash_guard_pkg::ABORT_BANK_CYC);
					else
						rec_d = CW'(flash_guard_pkg::ABORT_SEG_CYC);
				end else if (cnt_q <= CW'(1)) begin
					state_d = flash_guard_pkg::DEV_IDLE;
					done_d = 1'b1;
					mem_wr = (kind_q == flash_guard_pkg::OP_WRITE);
					mem_erase_all = !mem_wr;
				end
			end
			default: state_d = flash_guard_pkg::DEV_IDLE;
		endcase
	end

	// monitor settling; set wins over a clear in the same cycle
	always_comb begin
		lo_cnt_d = (lo_cnt_q != '0) ? lo_cnt_q - CW'(1) : lo_cnt_q;
		hi_cnt_d = (hi_cnt_q != '0) ? hi_cnt_q - CW'(1) : hi_cnt_q;
		lo_en_d = lo_en_q;
		lo_expire = (lo_cnt_q == CW'(1));
		hi_expire = (hi_cnt_q == CW'(1));
		if (fl.mon_prog && fl.mon_sel == flash_guard_pkg::MON_LOW) begin
			lo_cnt_d = CW'(SETTLE_CYC);
			lo_en_d = fl.low_monitor_enable;
		end
		if (fl.mon_prog && fl.mon_sel == flash_guard_pkg::MON_HIGH)
			hi_cnt_d = CW'(SETTLE_CYC);
		lo_flag_d = lo_expire ||
			(lo_flag_q && !(fl.flag_clr && fl.mon_sel == flash_guard_pkg::MON_LOW));
		hi_flag_d = hi_expire ||
			(hi_flag_q && !(fl.flag_clr && fl.mon_sel == flash_guard_pkg::MON_HIGH));
	end

	// reads: unreliable while busy, recovering, or hit by a low-side settle expiry while the low monitor is enabled
	always_comb begin
		rv_d = fl.rd;
		rdat_d = fl.rd ? mem[fl.op_addr] : rdat_q;
		bad_d = fl.rd && lo_en_q && lo_expire;
		rg_d = fl.rd && state_q == flash_guard_pkg::DEV_IDLE &&
			rec_q == '0 && !bad_d;
	end

	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			state_q <= flash_guard_pkg::DEV_IDLE;
			kind_q <= flash_guard_pkg::OP_WRITE;
			addr_q <= '0;
			wdata_q <= '0;
			cnt_q <= '0;
			rec_q <= '0;
			lo_cnt_q <= '0;
			hi_cnt_q <= '0;
			lo_flag_q <= 1'b0;
			hi_flag_q <= 1'b0;
			lo_en_q <= 1'b0;
			done_q <= 1'b0;
			abt_q <= 1'b0;
			rv_q <= 1'b0;
			rg_q <= 1'b0;
			bad_q <= 1'b0;
			rdat_q <= '0;
			irq_q <= 1'b0;
		end else begin
			state_q <= state_d;
			kind_q <= kind_d;
			addr_q <= addr_d;
			wdata_q <= wdata_d;
			cnt_q <= cnt_d;
			rec_q <= rec_d;
			lo_cnt_q <= lo_cnt_d;
			hi_cnt_q <= hi_cnt_d;
			lo_flag_q <= lo_flag_d;
			hi_flag_q <= hi_flag_d;
			lo_en_q <= lo_en_d;
			done_q <= done_d;
			abt_q <= abt_d;
			rv_q <= rv_d;
			rg_q <= rg_d;
			bad_q <= bad_d;
			rdat_q <= rdat_d;
			irq_q <= irq_src_in;
		end
	end

	// cell array has no reset; erase fills it whole for simplicity
	always_ff @(posedge core_clk_in) begin
		for (int i = 0; i < DEPTH; i++) begin
			if (mem_erase_all)
				mem[i] <= flash_guard_pkg::ERASED_WORD;
			else if (mem_wr && addr_q == flash_guard_pkg::ADDR_W'(i))
				mem[i] <= wdata_q;
		end
	end

	assign fl.busy = (state_q == flash_guard_pkg::DEV_BUSY);
	assign fl.rd_valid = rv_q;
	assign fl.rd_good = rg_q;
	assign fl.rd_data = rdat_q;
	assign fl.monitor_settle_delay_flag = lo_flag_q;
	assign fl.high_settle_flag = hi_flag_q;
	assign fl.irq_req = irq_q;
	assign op_done_out = done_q;
	assign op_aborted_out = abt_q;
	assign recovering_out = (rec_q != '0);
	assign read_corrupt_out = bad_q;
endmodule // flash_abort_device

//--- core/flash_abort_host.sv
// core end: issues flash work, aborts, irq gating, supply raise sequence
`timescale 1ns/1ps
module flash_abort_host (
	// clock and reset
	input  wire logic                                core_clk_in,
	input  wire logic                                reset_in,
	// link to the flash end
	flash_guard_if.host_end                          fl,
	// flash work requests
	input  wire logic                                op_req_in,
	input  wire flash_guard_pkg::op_kind_type        op_kind_in,
	input  wire logic [flash_guard_pkg::ADDR_W-1:0]  op_addr_in,
	input  wire logic [flash_guard_pkg::DATA_W-1:0]  op_data_in,
	input  wire logic                                other_bank_in,
	input  wire logic                                abort_req_in,
	// reads
	input  wire logic                                rd_req_in,
	input  wire logic [flash_guard_pkg::ADDR_W-1:0]  rd_addr_in,
	output logic                                     rd_valid_out,
	output logic                                     rd_good_out,
	output logic [flash_guard_pkg::DATA_W-1:0]       rd_data_out,
	// supply raise
	input  wire logic                                raise_req_in,
	input  wire logic [flash_guard_pkg::LEVEL_W-1:0] raise_level_in,
	output logic                                     raise_done_out,
	// interrupts and status
	output logic                                     irq_take_out,
	output logic                                     global_irq_enable_out,
	output logic                                     ready_out,
	output logic                                     blackout_out
);
	localparam int CW = flash_guard_pkg::CNT_W;
	localparam int LW = flash_guard_pkg::LEVEL_W;

	flash_guard_pkg::host_state_type     state_q, state_d;
	flash_guard_pkg::op_kind_type        kind_q, kind_d;
	logic [flash_guard_pkg::ADDR_W-1:0]  addr_q, addr_d;
	logic [flash_guard_pkg::DATA_W-1:0]  data_q, data_d;
	logic [CW-1:0]                       black_q, black_d;
	logic [LW-1:0]                       level_q, level_d;
	logic                                start_q, start_d, abort_q, abort_d;
	logic                                rd_q, rd_d, prog_q, prog_d;
	logic                                sel_q, sel_d, clr_q, clr_d;
	logic                                core_q, core_d;
	logic                                hi_en_q, hi_en_d, lo_en_q, lo_en_d;
	logic                                gie_q, gie_d, gie_save_q, gie_save_d;
	logic                                pend_q, pend_d, take_q, take_d;
	logic                                done_q, done_d;
	logic                                idle;

	assign idle = (state_q == flash_guard_pkg::HOST_IDLE);

	// main sequence: flash work, abort blackout and supply raise
	always_comb begin
		state_d = state_q;
		kind_d = kind_q;
		addr_d = addr_q;
		data_d = data_q;
		black_d = black_q;
		level_d = level_q;
		start_d = 1'b0;
		abort_d = 1'b0;
		rd_d = 1'b0;
		prog_d = 1'b0;
		sel_d = sel_q;
		clr_d = 1'b0;
		core_d = 1'b0;
		hi_en_d = hi_en_q;
		lo_en_d = lo_en_q;
		gie_d = gie_q;
		gie_save_d = gie_save_q;
		done_d = 1'b0;
		case (state_q)
			flash_guard_pkg::HOST_IDLE: begin
				if (raise_req_in) begin
					state_d = flash_guard_pkg::HOST_HI_WAIT;
					level_d = raise_level_in;
					prog_d = 1'b1;
					sel_d = flash_guard_pkg::MON_HIGH;
					hi_en_d = 1'b1;
				end else if (op_req_in) begin
					state_d = flash_guard_pkg::HOST_OP;
					start_d = 1'b1;
					kind_d = op_kind_in;
					addr_d = op_addr_in;
					data_d = op_data_in;
					gie_save_d = gie_q;
					if (op_kind_in != flash_guard_pkg::OP_WRITE &&
					    other_bank_in)
						gie_d = 1'b0;
				end else if (rd_req_in) begin
					rd_d = 1'b1;
					addr_d = rd_addr_in;
				end
			end
			flash_guard_pkg::HOST_OP: begin
				// busy shows one cycle after the start pulse
				if (abort_req_in && fl.busy) begin
					abort_d = 1'b1;
					state_d = flash_guard_pkg::HOST_BLACKOUT;
					if (kind_q == flash_guard_pkg::OP_BANK_ERASE ||
					    kind_q == flash_guard_pkg::OP_MASS_ERASE)
						black_d = CW'(flash_guard_pkg::ABORT_BANK_CYC);
					else
						black_d = CW'(flash_guard_pkg::ABORT_SEG_CYC);
				end else if (!fl.busy && !start_q) begin
					state_d = flash_guard_pkg::HOST_IDLE;
					gie_d = gie_save_q;
				end
			end
			flash_guard_pkg::HOST_BLACKOUT: begin
				// counted from the cycle the abort bit is set
				black_d = black_q - CW'(1);
				if (black_q <= CW'(2)) begin
					state_d = flash_guard_pkg::HOST_IDLE;
					gie_d = gie_save_q;
				end
			end
			flash_guard_pkg::HOST_HI_WAIT: begin
				if (fl.high_settle_flag && !prog_q) begin
					clr_d = 1'b1;
					state_d = flash_guard_pkg::HOST_CORE;
				end
			end
			flash_guard_pkg::HOST_CORE: begin
				core_d = 1'b1;
				prog_d = 1'b1;
				sel_d = flash_guard_pkg::MON_LOW;
				lo_en_d = 1'b1;
				state_d = flash_guard_pkg::HOST_LO_WAIT;
			end
			flash_guard_pkg::HOST_LO_WAIT: begin
				// no reads are issued here, so none meets the expiry
				if (fl.monitor_settle_delay_flag && !prog_q) begin
					clr_d = 1'b1;
					done_d = 1'b1;
					state_d = flash_guard_pkg::HOST_IDLE;
				end
			end
			default: state_d = flash_guard_pkg::HOST_IDLE;
		endcase
	end

	// pending interrupts wait for the enable; new request wins over take
	always_comb begin
		take_d = pend_q && gie_q;
		pend_d = fl.irq_req || (pend_q && !take_d);
	end

	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			state_q <= flash_guard_pkg::HOST_IDLE;
			kind_q <= flash_guard_pkg::OP_WRITE;
			addr_q <= '0;
			data_q <= '0;
			black_q <= '0;
			level_q <= '0;
			start_q <= 1'b0;
			abort_q <= 1'b0;
			rd_q <= 1'b0;
			prog_q <= 1'b0;
			sel_q <= flash_guard_pkg::MON_LOW;
			clr_q <= 1'b0;
			core_q <= 1'b0;
			hi_en_q <= 1'b0;
			lo_en_q <= 1'b0;
			gie_q <= 1'b1;
			gie_save_q <= 1'b1;
			pend_q <= 1'b0;
			take_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			state_q <= state_d;
			kind_q <= kind_d;
			addr_q <= addr_d;
			data_q <= data_d;
			black_q <= black_d;
			level_q <= level_d;
			start_q <= start_d;
			abort_q <= abort_d;
			rd_q <= rd_d;
			prog_q <= prog_d;
			sel_q <= sel_d;
			clr_q <= clr_d;
			core_q <= core_d;
			hi_en_q <= hi_en_d;
			lo_en_q <= lo_en_d;
			gie_q <= gie_d;
			gie_save_q <= gie_save_d;
			pend_q <= pend_d;
			take_q <= take_d;
			done_q <= done_d;
		end
	end

	assign fl.op_start = start_q;
	assign fl.op_kind = kind_q;
	assign fl.op_addr = addr_q;
	assign fl.op_data = data_q;
	assign fl.emergency_abort_bit = abort_q;
	assign fl.rd = rd_q;
	assign fl.mon_prog = prog_q;
	assign fl.mon_sel = sel_q;
	assign fl.high_release_level_unit = level_q;
	assign fl.high_monitor_enable = hi_en_q;
	assign fl.high_supervisor_enable = hi_en_q;
	assign fl.low_monitor_enable = lo_en_q;
	assign fl.low_monitor_full_perf = 1'b0;
	assign fl.core_set = core_q;
	assign fl.core_level = level_q;
	assign fl.flag_clr = clr_q;
	assign rd_valid_out = fl.rd_valid;
	assign rd_good_out = fl.rd_good;
	assign rd_data_out = fl.rd_data;
	assign raise_done_out = done_q;
	assign irq_take_out = take_q;
	assign global_irq_enable_out = gie_q;
	assign ready_out = idle;
	assign blackout_out = (state_q == flash_guard_pkg::HOST_BLACKOUT);
endmodule // flash_abort_host

//--- tb/flash_guard_props.sv
// link assertions for the flash abort guard pair
`timescale 1ns/1ps
module flash_guard_props #(
	parameter int WRITE_CYC      = 64,
	parameter int SEG_ERASE_CYC  = 1000,
	parameter int BANK_ERASE_CYC = 4000,
	parameter int MASS_ERASE_CYC = 4000
) (
	// clock and reset
	input wire logic                         core_clk_in,
	input wire logic                         reset_in,
	// link signals
	input wire logic                         op_start,
	input wire flash_guard_pkg::op_kind_type op_kind,
	input wire logic                         emergency_abort_bit,
	input wire logic                         busy,
	input wire logic                         rd,
	input wire logic                         mon_prog,
	input wire logic                         mon_sel,
	input wire logic                         low_monitor_full_perf,
	input wire logic                         core_set,
	input wire logic                         high_settle_flag,
	input wire logic                         monitor_settle_delay_flag
);
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (reset_in);
	flash_guard_pkg::op_kind_type kind_q, kind_d;
	logic [15:0] len_q, len_d, hold_q, hold_d, exp_len;
	logic        cut_q, cut_d, hi_q, hi_d;
	// bank and mass codes share bit 1, so one bit picks the long hold-off
	always_comb begin
		kind_d = op_start ? op_kind : kind_q;
		len_d = op_start ? 16'h0000 : len_q + 16'(busy);
		cut_d = !op_start && (cut_q || emergency_abort_bit);
		hi_d = high_settle_flag || (hi_q && !core_set);
		hold_d = hold_q - 16'(hold_q != 16'h0000);
		// the bit is seen one edge after it is set, so load one less
		if (emergency_abort_bit)
			hold_d = kind_q[1] ? 16'(flash_guard_pkg::ABORT_BANK_CYC - 1)
				: 16'(flash_guard_pkg::ABORT_SEG_CYC - 1);
		case (kind_q)
			flash_guard_pkg::OP_WRITE:     exp_len = 16'(WRITE_CYC);
			flash_guard_pkg::OP_SEG_ERASE: exp_len = 16'(SEG_ERASE_CYC);
			flash_guard_pkg::OP_BANK_ERASE: exp_len = 16'(BANK_ERASE_CYC);
			default:                       exp_len = 16'(MASS_ERASE_CYC);
		endcase
	end
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			kind_q <= flash_guard_pkg::OP_WRITE;
			len_q <= 16'h0000;
			hold_q <= 16'h0000;
			cut_q <= 1'b0;
			hi_q <= 1'b0;
		end else begin
			kind_q <= kind_d;
			len_q <= len_d;
			hold_q <= hold_d;
			cut_q <= cut_d;
			hi_q <= hi_d;
		end
	end
	sequence s_abort; emergency_abort_bit && busy; endsequence
	sequence s_core_step; core_set && !mon_sel; endsequence
	property p_abort_stop; s_abort |=> !busy; endproperty
	property p_busy_start; op_start |=> busy; endproperty
	property p_busy_len; $fell(busy) && !cut_q |-> len_q == exp_len; endproperty
	property p_bank_hold; hold_q != 0 && kind_q[1] |-> !rd && !op_start;
	endproperty
	property p_seg_hold; hold_q != 0 && !kind_q[1] |-> !rd && !op_start;
	endproperty
	property p_low_normal; mon_prog |-> !low_monitor_full_perf; endproperty
	property p_hi_first; s_core_step |-> hi_q; endproperty
	property p_settle_read;
		$rose(monitor_settle_delay_flag) |-> !rd && !$past(rd);
	endproperty
	a_abort_stop: assert property (p_abort_stop)
		else $error("busy still high after abort");
	a_busy_start: assert property (p_busy_start)
		else $error("busy not raised after start");
	a_busy_len: assert property (p_busy_len)
		else $error("busy length wrong");
	a_bank_hold: assert property (p_bank_hold)
		else $error("flash access in bank hold-off");
	a_seg_hold: assert property (p_seg_hold)
		else $error("flash access in segment hold-off");
	a_low_normal: assert property (p_low_normal)
		else $error("low monitor in full performance");
	a_hi_first: assert property (p_hi_first)
		else $error("core level set before high side settled");
	a_settle_read: assert property (p_settle_read)
		else $error("read at settle expiry");
endmodule // flash_guard_props

//--- tb/test_flash_abort_guard.sv
// self-checking bench for the flash abort guard pair
`timescale 1ns/1ps
module test_flash_abort_guard;
	localparam int WR = 16;
	localparam int SG = 40;
	localparam int BK = 60;
	logic        core_clk_in = 1'b0;
	logic        reset_in = 1'b1;
	logic        irq_src_in = 1'b0;
	logic        op_req_in = 1'b0;
	logic        other_bank_in = 1'b0;
	logic        abort_req_in = 1'b0;
	logic        rd_req_in = 1'b0;
	logic        raise_req_in = 1'b0;
	logic [1:0]  raise_level_in = 2'h0;
	logic [3:0]  op_addr_in = 4'h0;
	logic [3:0]  rd_addr_in = 4'h0;
	logic [15:0] op_data_in = 16'h0000;
	flash_guard_pkg::op_kind_type op_kind_in = flash_guard_pkg::OP_WRITE;
	logic        op_done_out, op_aborted_out, recovering_out;
	logic        read_corrupt_out, rd_valid_out, rd_good_out;
	logic        raise_done_out, irq_take_out, global_irq_enable_out;
	logic        ready_out, blackout_out;
	logic [15:0] rd_data_out;
	int          err_count = 0;
	int          comparisons = 0;
	int          seed = 42;
	always #12.5 core_clk_in = ~core_clk_in;
	flash_guard_if fl ();
	flash_abort_device #(.WRITE_CYC(WR), .SEG_ERASE_CYC(SG),
		.BANK_ERASE_CYC(BK), .MASS_ERASE_CYC(BK), .SETTLE_CYC(8))
		u_flash_abort_device (.core_clk_in, .reset_in, .fl(fl), .irq_src_in,
		.op_done_out, .op_aborted_out, .recovering_out, .read_corrupt_out);
	flash_abort_host u_flash_abort_host (.core_clk_in, .reset_in, .fl(fl),
		.op_req_in, .op_kind_in, .op_addr_in, .op_data_in, .other_bank_in,
		.abort_req_in, .rd_req_in, .rd_addr_in, .rd_valid_out, .rd_good_out,
		.rd_data_out, .raise_req_in, .raise_level_in, .raise_done_out,
		.irq_take_out, .global_irq_enable_out, .ready_out, .blackout_out);
	flash_guard_props #(.WRITE_CYC(WR), .SEG_ERASE_CYC(SG),
		.BANK_ERASE_CYC(BK), .MASS_ERASE_CYC(BK)) u_flash_guard_props (
		.core_clk_in, .reset_in, .op_start(fl.op_start),
		.op_kind(fl.op_kind), .emergency_abort_bit(fl.emergency_abort_bit),
		.busy(fl.busy), .rd(fl.rd), .mon_prog(fl.mon_prog),
		.mon_sel(fl.mon_sel), .low_monitor_full_perf(fl.low_monitor_full_perf),
		.core_set(fl.core_set), .high_settle_flag(fl.high_settle_flag),
		.monitor_settle_delay_flag(fl.monitor_settle_delay_flag));
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// every wait is bounded; running out ends the run as a failure
	task automatic bound(inout int n, input int lim);
		@(posedge core_clk_in);
		n++;
		if (n > lim) begin
			err_count++;
			$display("wrong value wait expected done seen timeout");
			give_verdict();
		end
	endtask
	task automatic wait_ready();
		int n;
		n = 0;
		while (ready_out !== 1'b1) bound(n, 5000);
	endtask
	function automatic int hold_of(flash_guard_pkg::op_kind_type k);
		return k[1] ? flash_guard_pkg::ABORT_BANK_CYC
			: flash_guard_pkg::ABORT_SEG_CYC;
	endfunction
	task automatic do_op(flash_guard_pkg::op_kind_type k, logic [3:0] a,
		logic [15:0] d, logic ob, logic cut);
		int n;
		logic m, tk;
		n = 0;
		tk = 1'b0;
		m = ob && k != flash_guard_pkg::OP_WRITE;
		wait_ready();
		op_req_in <= 1'b1;
		op_kind_in <= k;
		op_addr_in <= a;
		op_data_in <= d;
		other_bank_in <= ob;
		bound(n, 5);
		op_req_in <= 1'b0;
		while (fl.busy !== 1'b1) bound(n, 10);
		check("irq enable", global_irq_enable_out, !m);
		if (cut) begin
			abort_req_in <= 1'b1;
			bound(n, 20);
			abort_req_in <= 1'b0;
			while (op_aborted_out !== 1'b1) bound(n, 20);
			check("busy", fl.busy, 1'b0);
			check("recovering", recovering_out, 1'b1);
			check("blackout", blackout_out, 1'b1);
			n = 0;
			while (ready_out !== 1'b1) bound(n, 5000);
			// count starts two edges after the abort bit was set
			check("hold-off", 16'(n), 16'(hold_of(k) - 2));
			check("blackout end", blackout_out, 1'b0);
		end else begin
			irq_src_in <= 1'b1;
			while (op_done_out !== 1'b1) begin
				tk |= irq_take_out === 1'b1;
				bound(n, 200);
				irq_src_in <= 1'b0;
			end
			check("busy", fl.busy, 1'b0);
			check("irq in op", tk, !m);
			n = 0;
			while (m && irq_take_out !== 1'b1) bound(n, 10);
		end
	endtask
	task automatic do_read(logic [3:0] a, logic [15:0] d, logic chk);
		int n;
		n = 0;
		wait_ready();
		rd_req_in <= 1'b1;
		rd_addr_in <= a;
		bound(n, 5);
		rd_req_in <= 1'b0;
		while (rd_valid_out !== 1'b1) bound(n, 10);
		check("read good", rd_good_out, 1'b1);
		check("corrupt", read_corrupt_out, 1'b0);
		if (chk)
			check("read data", rd_data_out, d);
	endtask
	task automatic do_raise(logic [1:0] lv);
		int n;
		n = 0;
		wait_ready();
		raise_req_in <= 1'b1;
		raise_level_in <= lv;
		bound(n, 5);
		raise_req_in <= 1'b0;
		while (raise_done_out !== 1'b1) bound(n, 300);
		check("core level", fl.core_level, lv);
		check("high level", fl.high_release_level_unit, lv);
		check("full perf", fl.low_monitor_full_perf, 1'b0);
	endtask
	initial begin
		logic [3:0] a;
		logic [15:0] d;
		repeat (3) @(posedge core_clk_in);
		reset_in <= 1'b0;
		@(posedge core_clk_in);
		do_op(flash_guard_pkg::OP_MASS_ERASE, 4'h0, 16'h0000, 1'b0, 1'b0);
		do_read(4'h5, flash_guard_pkg::ERASED_WORD, 1'b1);
		for (int i = 0; i < 6; i++) begin
			a = 4'($random(seed));
			d = 16'($random(seed));
			do_op(flash_guard_pkg::OP_WRITE, a, d, 1'b0, 1'b0);
			do_read(a, d, 1'b1);
		end
		$display("test write done");
		// other-bank erase runs with interrupts held pending
		do_op(flash_guard_pkg::OP_SEG_ERASE, a, d, 1'b1, 1'b0);
		do_read(a, flash_guard_pkg::ERASED_WORD, 1'b1);
		do_op(flash_guard_pkg::OP_BANK_ERASE, a, d, 1'b0, 1'b0);
		$display("test erase done");
		for (int k = 0; k < 4; k++) begin
			d = 16'($random(seed));
			do_op(flash_guard_pkg::op_kind_type'(k), a, d, 1'b0, 1'b1);
			do_read(a, d, 1'b0);
		end
		$display("test abort done");
		do_op(flash_guard_pkg::OP_WRITE, a, d, 1'b0, 1'b0);
		for (int lv = 0; lv < 4; lv++) begin
			do_raise(2'(lv));
			do_read(a, d, 1'b1);
		end
		$display("test raise done");
		give_verdict();
	end
endmodule // test_flash_abort_guard
